// File: logic/ivp_map.sv
/*
 * Interrupt request mapping, level compare and vector selection.
 * Assumes sources are request levels on clk_i and the core gives
 * the level fields as a flat vector and unused-address read strobes.
 */
// Notes on behaviour
// - Lines 0..23 own vector pairs, line 0 highest, two bytes lower each.
// - Among equal-level pending requests, the lowest-numbered line wins.
// - Channels 2 and 6 share line 2; channels 4 and 5 drive lines 0, 1.
// - External channels 3 and 7 share line 3 with one vector and one level.
// - Timer 0 lower half raises line 5, upper half line 6.
// - Timer 1 upper half raises line 14.
// - Timer 1 lower half raises line 22, below lines 18 to 20.
// - An unused-address read completes; its data is not relied on.
// - Each line has its own two-bit level field used in arbitration.
`timescale 1ns/10ps
module ivp_map
    import ivp_pkg::*;
(
    input  wire logic                           clk_i,
    input  wire logic                           sys_rst_i,
    input  wire ivp_src_t                       src_i,
    input  wire logic [IVP_LINES*IVP_LVL_W-1:0] level_i,
    input  wire logic                           unused_rd_i,
    output logic [IVP_LINES-1:0]                req_o,
    output ivp_grant_t                          grant_o,
    output logic                                unused_rd_ack_o,
    output logic [7:0]                          unused_rd_data_o
);

    ////////////////////////////////////////////////////////////////////
    // Line mapping
    logic [IVP_LINES-1:0] req_d;
    logic [IVP_LINES-1:0] req_q;

    always_comb begin
        req_d = '0;
        req_d[IVP_L_EXT4]    = src_i.ext4;
        req_d[IVP_L_EXT5]    = src_i.ext5;
        req_d[IVP_L_EXT26]   = src_i.ext2 | src_i.ext6;
        req_d[IVP_L_EXT37]   = src_i.ext3 | src_i.ext7;
        req_d[IVP_L_T0LO]    = src_i.timer_lo0;
        req_d[IVP_L_T0HI]    = src_i.timer_hi0;
        req_d[IVP_L_UART_RX] = src_i.uart_rx;
        req_d[IVP_L_UART_TX] = src_i.uart_tx;
        req_d[IVP_L_T1HI]    = src_i.timer_hi1;
        req_d[IVP_L_ADC]     = src_i.adc;
        req_d[IVP_L_TBT]     = src_i.time_base;
        req_d[IVP_L_WPS]     = src_i.watch_pre;
        req_d[IVP_L_T1LO]    = src_i.timer_lo1;
        req_d[IVP_L_FLASH]   = src_i.flash;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    assign req_o = req_q;

    ////////////////////////////////////////////////////////////////////
    // Arbitration: lower level value is more urgent, then lower line
    ivp_grant_t win_d;
    ivp_grant_t grant_q;

    always_comb begin
        win_d       = '0;
        win_d.level = IVP_LVL_RESET;
        for (int i = IVP_LINES - 1; i >= 0; i--) begin
            if (req_q[i] &&
                (!win_d.valid ||
                 level_i[i*IVP_LVL_W +: IVP_LVL_W] <= win_d.level)) begin
                win_d.valid = 1'b1;
                win_d.line  = IVP_IDX_W'(i);
                win_d.level = level_i[i*IVP_LVL_W +: IVP_LVL_W];
            end
        end
        win_d.vector = IVP_VEC_TOP
                     - 16'(IVP_VEC_STEP * 16'(win_d.line));
        if (!win_d.valid) begin
            win_d = '0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            grant_q <= '0;
        end else begin
            grant_q <= win_d;
        end
    end

    assign grant_o = grant_q;

    ////////////////////////////////////////////////////////////////////
    // Unused-address reads answer next cycle with a fixed filler
    logic unused_ack_q;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            unused_ack_q <= 1'b0;
        end else begin
            unused_ack_q <= unused_rd_i;
        end
    end

    assign unused_rd_ack_o  = unused_ack_q;
    assign unused_rd_data_o = IVP_UNUSED_RD;

    ////////////////////////////////////////////////////////////////////
    // Checks
    localparam logic [IVP_LINES-1:0] IVP_IDLE_MASK = 24'h23be10;

    property p_idle_lines;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_o & IVP_IDLE_MASK) == '0;
    endproperty
    a_idle_lines: assert property (p_idle_lines)
        else $error("unassigned line active");

    property p_share2;
        @(posedge clk_i) disable iff (sys_rst_i)
        (src_i.ext2 || src_i.ext6) |=> req_o[2];
    endproperty
    a_share2: assert property (p_share2)
        else $error("line 2 not raised");

    property p_share3;
        @(posedge clk_i) disable iff (sys_rst_i)
        $past(src_i.ext3 | src_i.ext7) == req_o[3];
    endproperty
    a_share3: assert property (p_share3)
        else $error("line 3 mismatch");

    property p_hold_shared;
        @(posedge clk_i) disable iff (sys_rst_i)
        (src_i.ext6 && !src_i.ext2) |=> req_o[2];
    endproperty
    a_hold_shared: assert property (p_hold_shared)
        else $error("shared line dropped");

    property p_timer0;
        @(posedge clk_i) disable iff (sys_rst_i)
        src_i.timer_lo0 && src_i.timer_hi0 |=> req_o[5] && req_o[6];
    endproperty
    a_timer0: assert property (p_timer0)
        else $error("timer 0 lines wrong");

    property p_timer1;
        @(posedge clk_i) disable iff (sys_rst_i)
        src_i.timer_hi1 |=> req_o[14];
    endproperty
    a_timer1: assert property (p_timer1)
        else $error("timer 1 upper wrong");

    property p_t1lo_low;
        @(posedge clk_i) disable iff (sys_rst_i)
        req_o[22] && req_o[18] && level_i[45:44] == level_i[37:36]
            |=> grant_o.line != 5'h16;
    endproperty
    a_t1lo_low: assert property (p_t1lo_low)
        else $error("timer 1 lower beat converter");

    property p_vector;
        @(posedge clk_i) disable iff (sys_rst_i)
        grant_o.valid |->
            grant_o.vector == 16'hfffa - {10'h000, grant_o.line, 1'b0};
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector address wrong");

    property p_line0_wins;
        @(posedge clk_i) disable iff (sys_rst_i)
        req_o[0] && req_o[23] && level_i[1:0] == level_i[47:46]
            |=> grant_o.line != 5'h17;
    endproperty
    a_line0_wins: assert property (p_line0_wins)
        else $error("equal level order wrong");

    property p_level;
        @(posedge clk_i) disable iff (sys_rst_i)
        |req_o |=> grant_o.valid;
    endproperty
    a_level: assert property (p_level)
        else $error("pending request not granted");

    property p_unused;
        @(posedge clk_i) disable iff (sys_rst_i)
        unused_rd_i |=> unused_rd_ack_o;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused read not completed");

    property p_direct_ext;
        @(posedge clk_i) disable iff (sys_rst_i)
        $past(src_i.ext4) == req_o[IVP_L_EXT4]
            && $past(src_i.ext5) == req_o[IVP_L_EXT5];
    endproperty
    a_direct_ext: assert property (p_direct_ext)
        else $error("line 0 or 1 mismatch");

    property p_timer0_lo;
        @(posedge clk_i) disable iff (sys_rst_i)
        $past(src_i.timer_lo0) == req_o[IVP_L_T0LO];
    endproperty
    a_timer0_lo: assert property (p_timer0_lo)
        else $error("timer 0 lower line mismatch");

    property p_timer1_lo;
        @(posedge clk_i) disable iff (sys_rst_i)
        $past(src_i.timer_lo1) == req_o[IVP_L_T1LO];
    endproperty
    a_timer1_lo: assert property (p_timer1_lo)
        else $error("timer 1 lower line mismatch");

    property p_shared_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        !(src_i.ext2 || src_i.ext6) |=> !req_o[IVP_L_EXT26];
    endproperty
    a_shared_clear: assert property (p_shared_clear)
        else $error("shared line held after both cleared");

    property p_idle_grant;
        @(posedge clk_i) disable iff (sys_rst_i)
        !(|req_o) |=> !grant_o.valid;
    endproperty
    a_idle_grant: assert property (p_idle_grant)
        else $error("grant without pending request");

endmodule

// File: logic/ivp_pkg.sv
/*
 * Shared constants and carrier types for the interrupt vector and
 * priority map. Assumes one machine clock and one system reset.
 */
package ivp_pkg;

    localparam int          IVP_LINES      = 24;
    localparam int          IVP_LVL_W      = 2;
    localparam int          IVP_IDX_W      = 5;
    localparam logic [15:0] IVP_VEC_TOP    = 16'hfffa;
    localparam logic [15:0] IVP_VEC_STEP   = 16'h0002;
    localparam logic [1:0]  IVP_LVL_RESET  = 2'h3;
    localparam logic [7:0]  IVP_UNUSED_RD  = 8'h00;

    // Line numbers of the sources
    localparam int IVP_L_EXT4    = 0;
    localparam int IVP_L_EXT5    = 1;
    localparam int IVP_L_EXT26   = 2;
    localparam int IVP_L_EXT37   = 3;
    localparam int IVP_L_T0LO    = 5;
    localparam int IVP_L_T0HI    = 6;
    localparam int IVP_L_UART_RX = 7;
    localparam int IVP_L_UART_TX = 8;
    localparam int IVP_L_T1HI    = 14;
    localparam int IVP_L_ADC     = 18;
    localparam int IVP_L_TBT     = 19;
    localparam int IVP_L_WPS     = 20;
    localparam int IVP_L_T1LO    = 22;
    localparam int IVP_L_FLASH   = 23;

    typedef struct packed {
        logic ext2;
        logic ext3;
        logic ext4;
        logic ext5;
        logic ext6;
        logic ext7;
        logic timer_lo0;
        logic timer_hi0;
        logic timer_lo1;
        logic timer_hi1;
        logic uart_rx;
        logic uart_tx;
        logic adc;
        logic time_base;
        logic watch_pre;
        logic flash;
    } ivp_src_t;

    typedef struct packed {
        logic                 valid;
        logic [IVP_IDX_W-1:0] line;
        logic [IVP_LVL_W-1:0] level;
        logic [15:0]          vector;
    } ivp_grant_t;

endpackage

// File: verification/ivp_core_model.sv
/*
 * Core-side model: holds the level fields and issues unused reads.
 * Assumes one clock and the bench driving its command inputs.
 */
`timescale 1ns/10ps
module ivp_core_model
    import ivp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [47:0] lvl_set_i,
    input  wire logic        rd_go_i,
    output logic      [47:0] level_o,
    output logic             unused_rd_o
);
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            level_o <= {IVP_LINES{IVP_LVL_RESET}};
        end else begin
            level_o <= lvl_set_i;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Reads only; unused space is never written
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            unused_rd_o <= 1'b0;
        end else begin
            unused_rd_o <= rd_go_i;
        end
    end
endmodule

// File: verification/test_irq_vector_priority_map.sv
/*
 * Self-checking bench for the vector and priority map.
 * Assumes the core model supplies levels and unused reads.
 */
`timescale 1ns/10ps
module test_irq_vector_priority_map
    import ivp_pkg::*;
;
    logic        clk_i;
    logic        sys_rst_i;
    logic [15:0] src;
    logic [47:0] lvl_set;
    logic        rd_go;
    logic [47:0] level;
    logic        urd;
    logic [23:0] req;
    ivp_grant_t  grant;
    logic        ack;
    logic        gv_q;
    int          num_errors = 0;
    int          num_checks = 0;
    int          rd_pend = 0;
    logic [47:0] exp_q[$];
    logic [47:0] exp_e;

    ivp_core_model core (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .lvl_set_i(lvl_set), .rd_go_i(rd_go), .level_o(level),
        .unused_rd_o(urd));
    ivp_map dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .src_i(ivp_src_t'(src)), .level_i(level), .unused_rd_i(urd),
        .req_o(req), .grant_o(grant), .unused_rd_ack_o(ack),
        .unused_rd_data_o());
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    function automatic logic [47:0] predict(ivp_src_t s, logic [47:0] lv);
        logic [23:0] r;
        ivp_grant_t  g;
        r = {s.flash, s.timer_lo1, 1'b0, s.watch_pre, s.time_base, s.adc,
             3'h0, s.timer_hi1, 5'h00, s.uart_tx, s.uart_rx, s.timer_hi0,
             s.timer_lo0, 1'b0, s.ext3 | s.ext7, s.ext2 | s.ext6, s.ext5,
             s.ext4};
        g = '0;
        for (int n = 23; n >= 0; n--) begin
            if (r[n] && (!g.valid || lv[2*n+:2] <= g.level)) begin
                g = {1'b1, 5'(n), lv[2*n+:2], 16'hfffa - 16'(2 * n)};
            end
        end
        return {r, g};
    endfunction

    task automatic apply(input logic [15:0] s, input logic [47:0] lv);
        logic [47:0] e;
        e = predict(ivp_src_t'(s), lv);
        if (e[23]) begin
            exp_q.push_back(e);
        end
        @(posedge clk_i);
        src     <= s;
        lvl_set <= lv;
        repeat (4) @(posedge clk_i);
        src <= '0;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic rd(input int n);
        rd_pend += n;
        @(posedge clk_i);
        rd_go <= 1'b1;
        repeat (n) @(posedge clk_i);
        rd_go <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        gv_q <= grant.valid;
        if (!sys_rst_i && grant.valid === 1'b1 && gv_q !== 1'b1) begin
            exp_e = exp_q.size() ? exp_q.pop_front() : '1;
            check(48'(req), 48'(exp_e[47:24]));
            check(48'(req & 24'h23be10), 48'h0);
            check(48'(grant), 48'(exp_e[23:0]));
        end
        if (!sys_rst_i && ack === 1'b1) begin
            check(48'(rd_pend > 0), 48'h1);
            rd_pend--;
        end
    end

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    initial begin
        #100000;
        num_errors++;
        close_out();
    end

    initial begin
        sys_rst_i = 1'b1;
        src       = '0;
        lvl_set   = '1;
        rd_go     = 1'b0;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        void'($urandom(75));
        for (int i = 0; i < 16; i++) begin
            apply(16'h0001 << i, '1);
        end
        apply(16'hffff, '0);
        apply(16'h8400, '1);
        apply(16'h4100, '1);
        apply(16'h00e0, 48'h03f000000000);
        apply(16'h0088, '1);
        apply(16'h0300, '1);
        for (int i = 0; i < 60; i++) begin
            apply(16'($urandom()), 48'({$urandom(), $urandom()}));
        end
        rd(1);
        rd(3);
        check(48'(rd_pend), 48'h0);
        check(48'(exp_q.size()), 48'h0);
        close_out();
    end
endmodule
